// [hdx_defs.svh]
// timing counts, reset values and field positions for the half-duplex receive block
`ifndef HDX_DEFS_SVH
`define HDX_DEFS_SVH

`define HDX_CLK_HZ 10000000
`define HDX_CYC_PER_MS (`HDX_CLK_HZ / 1000)

`define HDX_DLY_1200_MS 30
`define HDX_DLY_2400_MS 15
`define HDX_DLY_4800_MS 8
`define HDX_DLY_9600_MS 5
`define HDX_DLY_19200_MS 3

`define HDX_DLY_W 19
`define HDX_TRC_W 11
`define HDX_TRACE_CAP 1024
`define HDX_RST_CYC 16
`define HDX_FIFO_DEPTH 16

`define HDX_ERR_OVR 2
`define HDX_ERR_FRM 1
`define HDX_ERR_PAR 0
`define HDX_CHAR_W 8
`define HDX_ENTRY_W 11

`define HDX_STATE_RST '0

`endif

// [hdx_pkg.sv]
// types shared by the half-duplex receive block
`include "hdx_defs.svh"
package hdx_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SEND,
    PH_HOLD,
    PH_RECV
  } hdx_phase_t;

  typedef enum logic [2:0] {
    BAUD_1200,
    BAUD_2400,
    BAUD_4800,
    BAUD_9600,
    BAUD_19200
  } hdx_baud_t;

  typedef struct packed {
    hdx_phase_t phase;
    logic [`HDX_DLY_W-1:0] dlyCnt;
    logic rcvOn;
    logic inMsg;
    logic [7:0] rcvCnt;
    logic [2:0] accErr;
    logic [2:0] errFlags;
    logic restartPend;
    logic restartBusy;
    logic [7:0] rstCnt;
    logic echoAct;
    logic echoBitPrev;
    logic fatal;
    logic [`HDX_TRC_W-1:0] traceCnt;
    logic trcVld;
    logic [`HDX_ENTRY_W-1:0] trcData;
    logic msgVld;
    logic [7:0] msgData;
    logic msgLast;
    logic rcvDone;
    logic sendCmpl;
  } hdx_port_t;

  typedef struct packed {
    hdx_port_t [1:0] p;
  } hdx_state_t;

endpackage

// [hdx_fifo.sv]
// receive buffer fifo with valid/ready on both sides and a flush input
`timescale 1ns/1ps
module hdx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // flush
  input wire logic clr,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } hdx_fifo_state_t;

  hdx_fifo_state_t state_ff;
  hdx_fifo_state_t nxt_state;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction

  assign inReady = (state_ff.count != (AW + 1)'(DEPTH));
  assign outValid = (state_ff.count != '0);
  assign outData = state_ff.mem[state_ff.rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    nxt_state = state_ff;
    if (clr) begin
      nxt_state.wrPtr = '0;
      nxt_state.rdPtr = '0;
      nxt_state.count = '0;
    end else begin
      if (push) begin
        nxt_state.mem[state_ff.wrPtr] = inData;
        nxt_state.wrPtr = bump(state_ff.wrPtr);
      end
      if (pop) begin
        nxt_state.rdPtr = bump(state_ff.rdPtr);
      end
      if (push && !pop) begin
        nxt_state.count = state_ff.count + (AW + 1)'(1);
      end else if (pop && !push) begin
        nxt_state.count = state_ff.count - (AW + 1)'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule

// [hdx_macro_rx.sv]
// two-port half-duplex macro receive path: buffer clearing, hold-off, errors, trace, restart
//
// Behaviour
// - buffer flushed at sequence start and again when the send part completes.
// - characters before send completion are dropped but still traced.
// - send completes only after a hold delay; characters inside it are dropped.
// - hold delay by baud: 30, 15, 8, 5, 3 ms for 1200 to 19200.
// - errored characters are buffered together with their error bits.
// - matched message sets the error flags its characters carry.
// - unmatched buffered data is skipped and leaves error flags untouched.
// - error bits go into the trace up to trace capacity.
// - restart request acts at next macro completion, never cuts a running macro.
// - restart request bit clears itself when restart processing ends.
// - echoback controls and status work only in macro mode with modem control.
// - per-port echoback disable bit, 1 disabled, hides own transmit while RTS.
// - disabled echoback: characters during RTS neither buffered nor traced.
// - setting the disable bit acts now; clearing waits for program start.
// - status flag shows the echoback setting in use, 1 disabled.
// - enabled echoback: echoed characters traced then dropped, no receive needed.
`timescale 1ns/1ps
`include "hdx_defs.svh"
module hdx_macro_rx
  import hdx_pkg::*;
#(
  parameter int DLY_1200_CYC = `HDX_DLY_1200_MS * `HDX_CYC_PER_MS,
  parameter int DLY_2400_CYC = `HDX_DLY_2400_MS * `HDX_CYC_PER_MS,
  parameter int DLY_4800_CYC = `HDX_DLY_4800_MS * `HDX_CYC_PER_MS,
  parameter int DLY_9600_CYC = `HDX_DLY_9600_MS * `HDX_CYC_PER_MS,
  parameter int DLY_19200_CYC = `HDX_DLY_19200_MS * `HDX_CYC_PER_MS,
  parameter int TRACE_CAP = `HDX_TRACE_CAP,
  parameter int RST_CYC = `HDX_RST_CYC,
  parameter int FIFO_DEPTH = `HDX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // macro sequencing, one bit per port, plus baud select and expected header and length fields per port
  input wire logic [1:0] seqStart,
  input wire logic [1:0] sendStart,
  input wire logic [1:0] sendDone,
  input wire logic [1:0] recvStart,
  input wire logic [1:0] macroDone,
  input wire logic [1:0] macroRunInstr,
  input wire logic [1:0][2:0] baudSel,
  input wire logic [1:0][7:0] expHead,
  input wire logic [1:0][7:0] expLen,
  // control bits
  input wire logic [1:0] restartReq,
  input wire logic [1:0] echoDisableBit,
  input wire logic [1:0] hostStart,
  input wire logic [1:0] modeMacro,
  input wire logic [1:0] modemCtl,
  input wire logic [1:0] rtsActive,
  input wire logic [1:0] traceEnable,
  // received characters from the deserialiser
  input wire logic [1:0] rxValid,
  output logic [1:0] rxReady,
  input wire logic [1:0][7:0] rxData,
  input wire logic [1:0][2:0] rxErr,
  // matched message out
  output logic [1:0] msgValid,
  output logic [1:0][7:0] msgData,
  output logic [1:0] msgLast,
  output logic [1:0] recvDone,
  output logic [1:0] sendComplete,
  // status
  output logic [1:0][2:0] errFlags,
  output logic [1:0] restartBit,
  output logic [1:0] echoStatus,
  output logic [1:0] fatalBoardError,
  // character trace
  output logic [1:0] traceValid,
  output logic [1:0][10:0] traceData,
  output logic [1:0] traceFull
);

  hdx_state_t state_ff;
  hdx_state_t nxt_state;
  logic [1:0] flushC;
  logic [1:0] canStore;
  logic [1:0] rxReadyC;
  logic [1:0] popC;
  logic [1:0] fifoInRdy;
  logic [1:0] fifoOutVld;
  logic [1:0][10:0] fifoOutData;
  logic [1:0][10:0] fifoInData;
  logic [1:0] echoEff;

  function automatic logic [`HDX_DLY_W-1:0] holdCycles(input logic [2:0] sel);
    case (hdx_baud_t'(sel))
      BAUD_1200: return `HDX_DLY_W'(DLY_1200_CYC);
      BAUD_2400: return `HDX_DLY_W'(DLY_2400_CYC);
      BAUD_4800: return `HDX_DLY_W'(DLY_4800_CYC);
      BAUD_9600: return `HDX_DLY_W'(DLY_9600_CYC);
      default: return `HDX_DLY_W'(DLY_19200_CYC);
    endcase
  endfunction

  // intake handshake, independent of rxValid
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      echoEff[i] = state_ff.p[i].echoAct & modeMacro[i] & modemCtl[i];
      canStore[i] = !rtsActive[i] && !state_ff.p[i].restartBusy &&
                    (state_ff.p[i].phase == PH_IDLE || state_ff.p[i].phase == PH_RECV);
      rxReadyC[i] = !canStore[i] || fifoInRdy[i];
      // no pop while a new receive starts, its entry would be lost
      popC[i] = state_ff.p[i].rcvOn && !recvStart[i] && !state_ff.p[i].restartBusy &&
                fifoOutVld[i];
      fifoInData[i] = {rxErr[i], rxData[i]};
    end
  end

  always_comb begin
    logic takeRx;
    logic [7:0] ch;
    logic [2:0] er;
    logic [2:0] acc;
    logic [2:0] errSet;
    logic [7:0] cnt;
    takeRx = 1'b0;
    ch = '0;
    er = '0;
    acc = '0;
    errSet = '0;
    cnt = '0;
    nxt_state = state_ff;
    flushC = '0;
    for (int i = 0; i < 2; i++) begin
      errSet = '0;
      nxt_state.p[i].trcVld = 1'b0;
      nxt_state.p[i].msgVld = 1'b0;
      nxt_state.p[i].msgLast = 1'b0;
      nxt_state.p[i].rcvDone = 1'b0;
      nxt_state.p[i].sendCmpl = 1'b0;

      // echoback setting in use
      if (hostStart[i]) begin
        nxt_state.p[i].echoAct = echoDisableBit[i];
      end else if (echoDisableBit[i] && !state_ff.p[i].echoBitPrev) begin
        nxt_state.p[i].echoAct = 1'b1;
      end
      nxt_state.p[i].echoBitPrev = echoDisableBit[i];

      // send phases
      if (seqStart[i]) begin
        flushC[i] = 1'b1;
      end
      case (state_ff.p[i].phase)
        PH_IDLE, PH_RECV: begin
          if (sendStart[i]) begin
            nxt_state.p[i].phase = PH_SEND;
          end
        end
        PH_SEND: begin
          if (sendDone[i]) begin
            nxt_state.p[i].phase = PH_HOLD;
            nxt_state.p[i].dlyCnt = holdCycles(baudSel[i]);
          end
        end
        PH_HOLD: begin
          if (state_ff.p[i].dlyCnt <= `HDX_DLY_W'(1)) begin
            nxt_state.p[i].phase = PH_RECV;
            nxt_state.p[i].sendCmpl = 1'b1;
            flushC[i] = 1'b1;
          end else begin
            nxt_state.p[i].dlyCnt = state_ff.p[i].dlyCnt - `HDX_DLY_W'(1);
          end
        end
        default: begin
          nxt_state.p[i].phase = PH_IDLE;
        end
      endcase
      if (macroDone[i]) begin
        nxt_state.p[i].phase = PH_IDLE;
      end

      // trace every accepted character except hidden echo, while traceEnable is set and the trace is below capacity
      takeRx = rxValid[i] && rxReadyC[i];
      if (takeRx && !(echoEff[i] && rtsActive[i]) && traceEnable[i] &&
          state_ff.p[i].traceCnt < `HDX_TRC_W'(TRACE_CAP)) begin
        nxt_state.p[i].trcVld = 1'b1;
        nxt_state.p[i].trcData = fifoInData[i];
        nxt_state.p[i].traceCnt = state_ff.p[i].traceCnt + `HDX_TRC_W'(1);
      end

      // receive: hunt for the header, then collect the message
      if (recvStart[i]) begin
        nxt_state.p[i].rcvOn = 1'b1;
        nxt_state.p[i].inMsg = 1'b0;
        nxt_state.p[i].rcvCnt = '0;
        nxt_state.p[i].accErr = '0;
      end else if (popC[i]) begin
        ch = fifoOutData[i][7:0];
        er = fifoOutData[i][10:8];
        if (state_ff.p[i].inMsg || ch == expHead[i]) begin
          acc = state_ff.p[i].inMsg ? (state_ff.p[i].accErr | er) : er;
          cnt = state_ff.p[i].inMsg ? (state_ff.p[i].rcvCnt + 8'h01) : 8'h01;
          nxt_state.p[i].inMsg = 1'b1;
          nxt_state.p[i].accErr = acc;
          nxt_state.p[i].rcvCnt = cnt;
          nxt_state.p[i].msgVld = 1'b1;
          nxt_state.p[i].msgData = ch;
          if (cnt >= expLen[i]) begin
            nxt_state.p[i].msgLast = 1'b1;
            nxt_state.p[i].rcvDone = 1'b1;
            nxt_state.p[i].rcvOn = 1'b0;
            nxt_state.p[i].inMsg = 1'b0;
            errSet = acc;
          end
        end
        // skipped characters drop their error bits here
      end

      // restart processing
      if (state_ff.p[i].restartBusy) begin
        flushC[i] = 1'b1;
        nxt_state.p[i].phase = PH_IDLE;
        nxt_state.p[i].rcvOn = 1'b0;
        nxt_state.p[i].inMsg = 1'b0;
        nxt_state.p[i].errFlags = '0;
        nxt_state.p[i].traceCnt = '0;
        if (macroRunInstr[i]) begin
          nxt_state.p[i].fatal = 1'b1;
        end
        if (state_ff.p[i].rstCnt == 8'h00) begin
          nxt_state.p[i].restartBusy = 1'b0;
          nxt_state.p[i].restartPend = 1'b0;
        end else begin
          nxt_state.p[i].rstCnt = state_ff.p[i].rstCnt - 8'h01;
        end
      end else if (state_ff.p[i].restartPend && macroDone[i]) begin
        nxt_state.p[i].restartBusy = 1'b1;
        nxt_state.p[i].rstCnt = 8'(RST_CYC - 1);
      end
      if (restartReq[i]) begin
        nxt_state.p[i].restartPend = 1'b1;
      end

      // set wins over the restart clear
      nxt_state.p[i].errFlags = nxt_state.p[i].errFlags | errSet;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= `HDX_STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : gPort
    // one buffer per port keeps the ports apart
    hdx_fifo #(
      .WIDTH(`HDX_ENTRY_W),
      .DEPTH(FIFO_DEPTH)
    ) uFifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clr(flushC[g]),
      .inValid(rxValid[g] & canStore[g]),
      .inReady(fifoInRdy[g]),
      .inData(fifoInData[g]),
      .outValid(fifoOutVld[g]),
      .outReady(popC[g]),
      .outData(fifoOutData[g])
    );

    assign rxReady[g] = rxReadyC[g];
    assign msgValid[g] = state_ff.p[g].msgVld;
    assign msgData[g] = state_ff.p[g].msgData;
    assign msgLast[g] = state_ff.p[g].msgLast;
    assign recvDone[g] = state_ff.p[g].rcvDone;
    assign sendComplete[g] = state_ff.p[g].sendCmpl;
    assign errFlags[g] = state_ff.p[g].errFlags;
    assign restartBit[g] = state_ff.p[g].restartPend;
    assign echoStatus[g] = state_ff.p[g].echoAct & modeMacro[g] & modemCtl[g];
    assign fatalBoardError[g] = state_ff.p[g].fatal;
    assign traceValid[g] = state_ff.p[g].trcVld;
    assign traceData[g] = state_ff.p[g].trcData;
    assign traceFull[g] = (state_ff.p[g].traceCnt >= `HDX_TRC_W'(TRACE_CAP));
  end
endmodule

// [hdx_macro_rx_properties.sv]
// concurrent checks on port A of the half-duplex receive block
`timescale 1ns/1ps
module hdx_macro_rx_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // sequencing and control
  input wire logic [1:0] sendDone,
  input wire logic [1:0] macroDone,
  input wire logic [1:0] restartReq,
  input wire logic [1:0] modeMacro,
  input wire logic [1:0] modemCtl,
  input wire logic [1:0] rtsActive,
  input wire logic [1:0] traceEnable,
  // received characters
  input wire logic [1:0] rxValid,
  input wire logic [1:0] rxReady,
  input wire logic [1:0][7:0] rxData,
  input wire logic [1:0][2:0] rxErr,
  // status and trace
  input wire logic [1:0] sendComplete,
  input wire logic [1:0][2:0] errFlags,
  input wire logic [1:0] restartBit,
  input wire logic [1:0] echoStatus,
  input wire logic [1:0] fatalBoardError,
  input wire logic [1:0] traceValid,
  input wire logic [1:0][10:0] traceData,
  input wire logic [1:0] traceFull
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_trace;
    rxValid[0] && rxReady[0] && traceEnable[0] && !rtsActive[0] && !traceFull[0]
      |=> traceValid[0] && traceData[0] == {$past(rxErr[0]), $past(rxData[0])};
  endproperty
  a_trace: assert property (p_trace) else $error("trace entry wrong");
  property p_rstSet;
    restartReq[0] |=> restartBit[0];
  endproperty
  a_rstSet: assert property (p_rstSet) else $error("restart bit not set");
  property p_rstBusy;
    macroDone[0] && restartBit[0] |=> restartBit[0] [*8];
  endproperty
  a_rstBusy: assert property (p_rstBusy) else $error("restart ended early");
  property p_rstClr;
    $fell(restartBit[0]) |-> errFlags[0] == 3'h0;
  endproperty
  a_rstClr: assert property (p_rstClr) else $error("flags kept after restart");
  property p_fatal;
    $rose(fatalBoardError[0]) |-> $past(restartBit[0]);
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal outside restart");
  property p_echoGate;
    !(modeMacro[0] && modemCtl[0]) |-> !echoStatus[0];
  endproperty
  a_echoGate: assert property (p_echoGate) else $error("echo status ungated");
  property p_echoNoTrace;
    echoStatus[0] && rtsActive[0] && rxValid[0] |=> !traceValid[0];
  endproperty
  a_echoNoTrace: assert property (p_echoNoTrace) else $error("echo traced");
  property p_sendMin;
    sendDone[0] |=> !sendComplete[0] [*3];
  endproperty
  a_sendMin: assert property (p_sendMin) else $error("send completed early");
endmodule

// [hdx_serial_dev.sv]
// serial device model feeding received characters into one port
`timescale 1ns/1ps
module hdx_serial_dev (
  // clock
  input wire logic clk_sys,
  // character handshake
  input wire logic rxReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic [2:0] rxErr
);
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxErr = 3'h0;
  end
  // released line shows the inverse of the last character
  task automatic idle();
    rxValid = 1'b0;
    rxData = ~rxData;
    rxErr = ~rxErr;
  endtask
  // offer one char after gap falling edges, held until taken
  task automatic send(input logic [7:0] d, input logic [2:0] e, input int gap);
    if (gap > 0) idle();
    repeat (gap) @(negedge clk_sys);
    rxValid = 1'b1;
    rxData = d;
    rxErr = e;
    // ready looked at once settled, ahead of the edge that takes the char
    #1;
    while (rxReady !== 1'b1) begin
      @(negedge clk_sys);
      #1;
    end
    @(negedge clk_sys);
  endtask
endmodule

// [test_hdx_macro_rx.sv]
// self-checking bench for the half-duplex receive block
`timescale 1ns/1ps
module test_hdx_macro_rx;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] seqStart, sendStart, sendDone, recvStart, macroDone, macroRunInstr;
  logic [1:0] restartReq, echoDisableBit, hostStart, modeMacro, modemCtl, rtsActive, traceEnable;
  logic [1:0][2:0] baudSel;
  logic [1:0][7:0] expHead, expLen;
  wire [1:0] rxValid, rxReady, msgValid, msgLast, recvDone, sendComplete;
  wire [1:0] restartBit, echoStatus, fatalBoardError, traceValid, traceFull;
  wire [1:0][7:0] rxData, msgData;
  wire [1:0][2:0] rxErr, errFlags;
  wire [1:0][10:0] traceData;
  int n_mismatch, tests_run, cyc, nTrc, tSd, tSc, i, k, b, len, n0;
  int dly[5] = '{30, 15, 8, 5, 3};
  int seed = 32'hDAD1;
  localparam int TRC_CAP = 8;
  logic [7:0] d;
  logic [2:0] er, eAll;
  logic [7:0] want[$], got[$];
  hdx_macro_rx #(.DLY_1200_CYC(30), .DLY_2400_CYC(15), .DLY_4800_CYC(8), .DLY_9600_CYC(5),
    .DLY_19200_CYC(3), .TRACE_CAP(TRC_CAP)) hdx_macro_rx_i (.clk_sys, .rst_n, .seqStart,
    .sendStart, .sendDone,
    .recvStart, .macroDone, .macroRunInstr, .baudSel, .expHead, .expLen, .restartReq,
    .echoDisableBit, .hostStart, .modeMacro, .modemCtl, .rtsActive, .traceEnable, .rxValid,
    .rxReady, .rxData, .rxErr, .msgValid, .msgData, .msgLast, .recvDone, .sendComplete,
    .errFlags, .restartBit, .echoStatus, .fatalBoardError, .traceValid, .traceData, .traceFull);
  hdx_serial_dev devA (.clk_sys, .rxReady(rxReady[0]), .rxValid(rxValid[0]),
    .rxData(rxData[0]), .rxErr(rxErr[0]));
  hdx_serial_dev devB (.clk_sys, .rxReady(rxReady[1]), .rxValid(rxValid[1]),
    .rxData(rxData[1]), .rxErr(rxErr[1]));
  always #50 clk_sys = ~clk_sys;
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [10:0] exp, input logic [10:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(ref logic [1:0] s, input int p);
    s[p] = 1'b1;
    @(negedge clk_sys);
    s[p] = 1'b0;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (sendDone[0] === 1'b1) tSd = cyc;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // registered outputs read half a cycle after their launching edge
  always @(negedge clk_sys) begin
    if (msgValid[0] === 1'b1) got.push_back(msgData[0]);
    if (traceValid[0] === 1'b1) nTrc++;
    if (sendComplete[0] === 1'b1) tSc = cyc;
  end
  initial begin
    {seqStart, sendStart, sendDone, recvStart, macroDone, macroRunInstr} = '0;
    {restartReq, echoDisableBit, hostStart, rtsActive, baudSel, expHead, expLen} = '0;
    {modeMacro, modemCtl, traceEnable} = '1;
    eAll = 3'h0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    for (i = 0; i < 16; i++) devA.send(8'h10 + 8'(i), 3'h0, 0);
    #1 cmp("ready when full", 11'h0, 11'(rxReady[0]));
    cmp("trace count", 11'(TRC_CAP), 11'(nTrc));
    cmp("trace full", 11'h1, 11'(traceFull[0]));
    @(negedge clk_sys);
    devA.idle();
    pulse(seqStart, 0);
    cmp("ready after flush", 11'h1, 11'(rxReady[0]));
    $display("buffer test done");
    @(negedge clk_sys);
    for (b = 0; b < 5; b++) begin
      len = 2 + ($unsigned($random(seed)) % 4);
      baudSel[0] = 3'(b);
      expHead[0] = 8'hA5;
      expLen[0] = 8'(len);
      pulse(seqStart, 0);
      pulse(sendStart, 0);
      devA.send(8'hA5, 3'h4, 0);
      devA.idle();
      pulse(sendDone, 0);
      devA.send(8'hA5, 3'h1, 0);
      devA.idle();
      for (k = 0; k < 400 && sendComplete[0] !== 1'b1; k++) @(negedge clk_sys);
      devA.send(8'h5A, 3'h2, 1);
      want.delete();
      for (i = 0; i < len; i++) begin
        d = (i == 0) ? 8'hA5 : 8'($random(seed));
        er = (i == 1) ? 3'($random(seed)) : 3'h0;
        eAll |= er;
        want.push_back(d);
        devA.send(d, er, $unsigned($random(seed)) % 3);
      end
      devA.idle();
      got.delete();
      pulse(recvStart, 0);
      for (k = 0; k < 100 && recvDone[0] !== 1'b1; k++) @(negedge clk_sys);
      cmp("last flag", 11'h1, 11'(msgLast[0]));
      cmp("error flags", 11'(eAll), 11'(errFlags[0]));
      cmp("port B flags", 11'h0, 11'(errFlags[1]));
      @(negedge clk_sys);
      cmp("message length", 11'(len), 11'(got.size()));
      for (i = 0; i < len; i++) cmp("message byte", 11'(want[i]), 11'(got[i]));
      cmp("hold delay", 11'(dly[b]), 11'(tSc - tSd));
      pulse(macroDone, 0);
      $display("baud test %0d done", b);
    end
    pulse(restartReq, 0);
    repeat (4) @(negedge clk_sys);
    cmp("restart pending", 11'h1, 11'(restartBit[0]));
    cmp("port B restart", 11'h0, 11'(restartBit[1]));
    pulse(macroDone, 0);
    for (k = 0; k < 60 && restartBit[0] !== 1'b0; k++) @(negedge clk_sys);
    cmp("restart self clear", 11'h0, 11'(restartBit[0]));
    echoDisableBit[0] = 1'b1;
    repeat (2) @(negedge clk_sys);
    cmp("echo status set", 11'h1, 11'(echoStatus[0]));
    cmp("port B echo", 11'h0, 11'(echoStatus[1]));
    rtsActive[0] = 1'b1;
    n0 = nTrc;
    devA.send(8'h33, 3'h0, 0);
    devA.send(8'h34, 3'h0, 1);
    devA.idle();
    repeat (2) @(negedge clk_sys);
    cmp("trace while disabled", 11'(n0), 11'(nTrc));
    echoDisableBit[0] = 1'b0;
    modeMacro[0] = 1'b0;
    #1 cmp("echo gated", 11'h0, 11'(echoStatus[0]));
    @(negedge clk_sys);
    modeMacro[0] = 1'b1;
    #1 cmp("echo held", 11'h1, 11'(echoStatus[0]));
    @(negedge clk_sys);
    pulse(hostStart, 0);
    cmp("echo after start", 11'h0, 11'(echoStatus[0]));
    n0 = nTrc;
    expHead[0] = 8'h44;
    expLen[0] = 8'h01;
    devA.send(8'h44, 3'h0, 0);
    devA.idle();
    rtsActive[0] = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp("echo traced", 11'(n0 + 1), 11'(nTrc));
    got.delete();
    pulse(recvStart, 0);
    repeat (6) @(negedge clk_sys);
    cmp("echo dropped", 11'h0, 11'(got.size()));
    pulse(restartReq, 0);
    pulse(macroDone, 0);
    macroRunInstr[0] = 1'b1;
    @(negedge clk_sys);
    macroRunInstr[0] = 1'b0;
    @(negedge clk_sys);
    cmp("run during restart", 11'h1, 11'(fatalBoardError[0]));
    cmp("port B fatal", 11'h0, 11'(fatalBoardError[1]));
    $display("restart and echo tests done");
    stop_test();
  end
endmodule
bind hdx_macro_rx hdx_macro_rx_properties hdx_macro_rx_properties_i (.clk_sys, .rst_n,
  .sendDone, .macroDone, .restartReq, .modeMacro, .modemCtl, .rtsActive, .traceEnable,
  .rxValid, .rxReady, .rxData, .rxErr, .sendComplete, .errFlags, .restartBit, .echoStatus,
  .fatalBoardError, .traceValid, .traceData, .traceFull);
